// ===== hw/snf_front_end.sv
// serial nand front end: x1/x2/x4 link, pause, cache, protection
`timescale 1ns/100ps
`include "snf_params.svh"
// What this block does
// - link runs in clock mode 0 or 3, host chooses which.
// - bits sampled on rising serial clock, driven out on falling.
// - x2 commands use lines 0 and 1 to send data out only.
// - x4 commands also use write-protect and pause pins as lines 2, 3.
// - pause stops only serial traffic, array work carries on.
// - pause starts with select low, pause pin low, clock low.
// - pause ends with pause pin high once clock is low.
// - while paused outputs float, data and clock ignored.
// - select high during pause resets the interface logic.
// - column address 12 bits, only 0 to 2111 exist.
// - row bits 5..0 pick page, bits 15..6 pick block.
// - page is 2048 main bytes plus 64 spare bytes.
// - lock bit set and write-protect low freezes protection bits.
// - after power-up page zero of block zero loads into cache.
// - with ecc on, check codes built per 512-byte unit on program.
// - page load with ecc reports the ecc result in status.
// - spare bytes stay reachable with ecc on.
// - cache reads wrap at 2112, 2048, 64 or 16 bytes.
// - array pages pass via data register, cache serves host.
// - cache read carries 2 wrap bits, 2 unused bits, then 12-bit column.
// - lock and protection bits live in feature address a0.
module snf_front_end #(
   parameter int CACHE_BYTES = `SNF_CACHE_BYTES
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   // serial link
   input wire logic SCLK_IN,
   input wire logic CS_N_IN,
   input wire logic [3:0] IO_LINE_IN,
   output logic [3:0] IO_LINE_OUT,
   output logic [3:0] IO_LINE_OE_N_OUT,
   // data register side
   input wire logic ECC_ENABLE_IN,
   input wire logic PAGE_WR_IN,
   input wire logic [11:0] PAGE_COL_IN,
   input wire logic [7:0] PAGE_DATA_IN,
   input wire logic PAGE_DONE_IN,
   input wire snf_pkg::snf_ecc_t PAGE_ECC_IN,
   output logic LOAD_REQ_OUT,
   output logic [15:0] LOAD_ROW_OUT,
   output logic [31:0] ECC_CODE_OUT,
   // status
   output snf_pkg::snf_ecc_t ECC_STATUS_OUT,
   output logic [7:0] PROTECT_OUT,
   output logic PAUSED_OUT
);
   import snf_pkg::*;
   localparam logic [11:0] CACHE_END = 12'(CACHE_BYTES);
   // lane count of an opcode's data phase
   function automatic logic [2:0] op_width(input logic [7:0] op);
      case (op)
         `SNF_OP_RD2: op_width = 3'h2;
         `SNF_OP_RD4, `SNF_OP_PL4: op_width = 3'h4;
         default: op_width = 3'h1;
      endcase
   endfunction
   // next read column inside the chosen wrap section
   function automatic logic [11:0] wrap_next(input logic [11:0] c, input logic [1:0] w);
      case (w)
         `SNF_WRAP_2048: wrap_next = {c[11], c[10:0] + 11'h001};
         `SNF_WRAP_64: wrap_next = {c[11:6], c[5:0] + 6'h01};
         `SNF_WRAP_16: wrap_next = {c[11:4], c[3:0] + 4'h1};
         default: wrap_next = (c >= `SNF_LAST_COL) ? 12'h000 : c + 12'h001;
      endcase
   endfunction
   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == `SNF_OP_RD) || (op == `SNF_OP_FRD) || (op == `SNF_OP_RD2) || (op == `SNF_OP_RD4);
   endfunction
   function automatic logic is_feat(input logic [7:0] op);
      is_feat = (op == `SNF_OP_GETF) || (op == `SNF_OP_SETF);
   endfunction
   // two-flop synchronisers for clock, select and data lines
   logic [5:0] sy1_q, sy2_q;
   logic sclk_prev_q;
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         sy1_q <= `SNF_SYNC_IDLE; // idle pin levels, no false clock edge after reset
         sy2_q <= `SNF_SYNC_IDLE;
         sclk_prev_q <= 1'b0;
      end else begin
         sy1_q <= {SCLK_IN, CS_N_IN, IO_LINE_IN};
         sy2_q <= sy1_q;
         sclk_prev_q <= sy2_q[5];
      end
   end
   logic sclk, cs_n, rise, fall;
   logic [3:0] io;
   assign sclk = sy2_q[5];
   assign cs_n = sy2_q[4];
   assign io = sy2_q[3:0];
   // both modes sample rising and drive falling, idle level irrelevant
   assign rise = sclk & ~sclk_prev_q;
   assign fall = ~sclk & sclk_prev_q;
   // serial engine state
   snf_state_t state_q, state_d;
   logic [4:0] bits_q, bits_d;
   logic [7:0] sh_q, sh_d, op_q, op_d, outsh_q, outsh_d, prot_q, prot_d;
   logic [15:0] addr_q, addr_d;
   logic [11:0] col_q, col_d;
   logic [1:0] wrap_q, wrap_d;
   logic [3:0] outcnt_q, outcnt_d, io_out_q, io_out_d, oe_n_q, oe_n_d;
   logic [31:0] ecc_q, ecc_d;
   logic paused_q, paused_d, wr_en;
   logic [2:0] wid;
   logic [7:0] new_sh, rd_byte, src;
   logic [7:0] cache_mem [0:CACHE_BYTES-1];
   assign rd_byte = (col_q < CACHE_END) ? cache_mem[col_q] : 8'hff;
   // next values of the serial engine
   always_comb begin
      state_d = state_q;
      bits_d = bits_q;
      sh_d = sh_q;
      op_d = op_q;
      addr_d = addr_q;
      col_d = col_q;
      wrap_d = wrap_q;
      prot_d = prot_q;
      ecc_d = ecc_q;
      outsh_d = outsh_q;
      outcnt_d = outcnt_q;
      io_out_d = io_out_q;
      wr_en = 1'b0;
      src = 8'h00;
      wid = (state_q == ST_DIN || state_q == ST_DOUT) ? op_width(op_q) : 3'h1;
      case (wid)
         3'h4: new_sh = {sh_q[3:0], io[3:0]};
         3'h2: new_sh = {sh_q[5:0], io[1:0]};
         default: new_sh = {sh_q[6:0], io[0]};
      endcase
      paused_d = paused_q; // pause entry and exit wait for a low clock
      if (cs_n) begin
         paused_d = 1'b0;
      end else if (!paused_q && !io[3] && wid != 3'h4 && !sclk) begin
         paused_d = 1'b1;
      end else if (paused_q && io[3] && !sclk) begin
         paused_d = 1'b0;
      end
      if (cs_n) begin
         state_d = ST_IDLE;
         bits_d = 5'h00;
      end else if (state_q == ST_IDLE) begin
         state_d = ST_CMD;
         bits_d = 5'h00;
      end else if (rise && !paused_q) begin
         bits_d = bits_q + {2'b00, wid};
         sh_d = new_sh;
         addr_d = {addr_q[14:0], io[0]};
         case (state_q)
            ST_CMD: begin
               if (bits_d == `SNF_BYTE_BITS) begin
                  op_d = new_sh;
                  bits_d = 5'h00;
                  state_d = ST_DONE;
                  if (is_read(new_sh) || is_feat(new_sh)) begin
                     state_d = ST_ADDR;
                  end
                  if (new_sh == `SNF_OP_PL || new_sh == `SNF_OP_PL4) begin
                     state_d = ST_ADDR;
                     ecc_d = 32'h0;
                  end
               end
            end
            ST_ADDR: begin
               if (bits_d == (is_feat(op_q) ? `SNF_FADDR_BITS : `SNF_ADDR_BITS)) begin
                  bits_d = 5'h00;
                  outcnt_d = 4'h0;
                  col_d = addr_d[11:0];
                  wrap_d = addr_d[15:14];
                  if (is_read(op_q)) begin
                     state_d = ST_DUMMY;
                  end else if (op_q == `SNF_OP_GETF) begin
                     state_d = ST_DOUT;
                  end else begin
                     state_d = ST_DIN;
                  end
               end
            end
            ST_DUMMY: begin
               if (bits_d == `SNF_DUMMY_BITS) begin
                  bits_d = 5'h00;
                  state_d = ST_DOUT;
               end
            end
            ST_DIN: begin
               if (bits_d == `SNF_BYTE_BITS) begin
                  bits_d = 5'h00;
                  if (op_q == `SNF_OP_SETF) begin
                     state_d = ST_DONE;
                     if (col_q[7:0] == `SNF_FEAT_PROT && !(prot_q[`SNF_LOCK_BIT] && !io[2])) begin
                        prot_d = new_sh & `SNF_PROT_WMASK;
                     end
                  end else begin
                     wr_en = (col_q < CACHE_END);
                     if (ECC_ENABLE_IN && col_q < `SNF_MAIN_BYTES) begin
                        ecc_d[{col_q[10:9], 3'b000} +: 8] = ecc_q[{col_q[10:9], 3'b000} +: 8] ^ new_sh;
                     end
                     col_d = col_q + 12'h001;
                  end
               end
            end
            default: ;
         endcase
      end else if (fall && !paused_q && state_q == ST_DOUT) begin
         if (outcnt_q == 4'h0) begin // fresh byte once the last is spent
            if (op_q == `SNF_OP_GETF) begin
               src = (col_q[7:0] == `SNF_FEAT_PROT) ? prot_q : 8'h00;
            end else begin
               src = rd_byte;
               col_d = wrap_next(col_q, wrap_q);
            end
         end else begin
            src = outsh_q;
         end
         case (wid)
            3'h4: io_out_d = src[7:4];
            3'h2: io_out_d = {2'b00, src[7:6]};
            default: io_out_d = {2'b00, src[7], 1'b0};
         endcase
         outsh_d = src << wid;
         outcnt_d = ((outcnt_q == 4'h0) ? 4'h8 : outcnt_q) - {1'b0, wid};
      end
      // drive only the lanes of the active width, float while paused
      if (state_q == ST_DOUT && !paused_q && !cs_n) begin
         oe_n_d = (wid == 3'h4) ? 4'h0 : (wid == 3'h2) ? `SNF_OE_X2 : `SNF_OE_X1;
      end else begin
         oe_n_d = `SNF_HI_Z;
      end
   end
   // serial engine registers
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         state_q <= ST_IDLE;
         bits_q <= 5'h00;
         sh_q <= 8'h00;
         op_q <= 8'h00;
         addr_q <= 16'h0000;
         col_q <= 12'h000;
         wrap_q <= 2'h0;
         prot_q <= `SNF_PROT_RST;
         ecc_q <= 32'h0;
         outsh_q <= 8'h00;
         outcnt_q <= 4'h0;
         io_out_q <= 4'h0;
         oe_n_q <= `SNF_HI_Z;
         paused_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bits_q <= bits_d;
         sh_q <= sh_d;
         op_q <= op_d;
         addr_q <= addr_d;
         col_q <= col_d;
         wrap_q <= wrap_d;
         prot_q <= prot_d;
         ecc_q <= ecc_d;
         outsh_q <= outsh_d;
         outcnt_q <= outcnt_d;
         io_out_q <= io_out_d;
         oe_n_q <= oe_n_d;
         paused_q <= paused_d;
      end
   end
   // cache register, filled from the data register or the host
   always_ff @(posedge CLK_IN) begin
      if (PAGE_WR_IN && PAGE_COL_IN < CACHE_END) begin
         cache_mem[PAGE_COL_IN] <= PAGE_DATA_IN;
      end else if (wr_en) begin
         cache_mem[col_q] <= new_sh;
      end
   end
   // boot page load request and ecc result
   logic load_q, load_d;
   snf_ecc_t eccst_q, eccst_d;
   always_comb begin
      load_d = load_q & ~PAGE_DONE_IN;
      eccst_d = eccst_q;
      if (PAGE_DONE_IN) begin
         eccst_d = ECC_ENABLE_IN ? PAGE_ECC_IN : 2'h0;
      end
   end
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         load_q <= 1'b1;
         eccst_q <= 2'h0;
      end else begin
         load_q <= load_d;
         eccst_q <= eccst_d;
      end
   end
   // outputs straight from flops, load row fixed to the boot page
   assign IO_LINE_OUT = io_out_q;
   assign IO_LINE_OE_N_OUT = oe_n_q;
   assign LOAD_REQ_OUT = load_q;
   assign LOAD_ROW_OUT = {`SNF_BOOT_BLOCK, `SNF_BOOT_PAGE};
   assign ECC_CODE_OUT = ecc_q;
   assign ECC_STATUS_OUT = eccst_q;
   assign PROTECT_OUT = prot_q;
   assign PAUSED_OUT = paused_q;
   // checks
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN);
   a_pause_floats: assert property (paused_q |=> oe_n_q == `SNF_HI_Z)
      else $error("lines driven while paused");
   a_deselect_idle: assert property (cs_n |=> state_q == ST_IDLE)
      else $error("select high did not idle the engine");
   a_pause_reset: assert property (paused_q && cs_n |=> !paused_q && state_q == ST_IDLE)
      else $error("deselect in pause did not reset");
   a_pause_entry_low: assert property ($rose(paused_q) |-> !$past(sclk))
      else $error("pause began with clock high");
   a_pause_exit_low: assert property ($fell(paused_q) && !$past(cs_n) |-> !$past(sclk) && $past(io[3]))
      else $error("pause ended with clock high");
   a_out_on_fall: assert property ($changed(io_out_q) |-> $past(fall) && !$past(paused_q))
      else $error("output changed off a falling edge");
   a_protect_locked: assert property (prot_q[`SNF_LOCK_BIT] && !io[2] |=> $stable(prot_q))
      else $error("locked protection bits changed");
   a_ecc_result: assert property (PAGE_DONE_IN && ECC_ENABLE_IN |=> ECC_STATUS_OUT == $past(PAGE_ECC_IN))
      else $error("ecc result not reported");
   a_boot_load_held: assert property (LOAD_REQ_OUT && !PAGE_DONE_IN |=> LOAD_REQ_OUT)
      else $error("boot load request dropped early");
   a_wrap_sixteen: assert property (fall && !paused_q && state_q == ST_DOUT && outcnt_q == 4'h0
      && op_q != `SNF_OP_GETF && wrap_q == `SNF_WRAP_16 && col_q[3:0] == 4'hf
      |=> col_q[3:0] == 4'h0 && $stable(col_q[11:4]))
      else $error("16-byte wrap missed");
   c_pause: cover property ($rose(paused_q));
   c_quad_out: cover property (state_q == ST_DOUT && wid == 3'h4 && fall);
   c_prot_write: cover property ($changed(prot_q));
   c_prog_byte: cover property (wr_en);
endmodule // snf_front_end

// ===== include/snf_params.svh
// constants for the serial nand front end
`ifndef SNF_PARAMS_SVH
`define SNF_PARAMS_SVH
`define SNF_CACHE_BYTES 2112
`define SNF_MAIN_BYTES 12'h800
`define SNF_LAST_COL 12'h83f
`define SNF_OP_RD 8'h03
`define SNF_OP_FRD 8'h0b
`define SNF_OP_RD2 8'h3b
`define SNF_OP_RD4 8'h6b
`define SNF_OP_PL 8'h02
`define SNF_OP_PL4 8'h32
`define SNF_OP_GETF 8'h0f
`define SNF_OP_SETF 8'h1f
`define SNF_FEAT_PROT 8'ha0
`define SNF_PROT_RST 8'h00
`define SNF_PROT_WMASK 8'hbe
`define SNF_LOCK_BIT 7
`define SNF_ADDR_BITS 5'h10
`define SNF_FADDR_BITS 5'h08
`define SNF_BYTE_BITS 5'h08
`define SNF_DUMMY_BITS 5'h08
`define SNF_BOOT_BLOCK 10'h000
`define SNF_BOOT_PAGE 6'h00
`define SNF_WRAP_2048 2'h1
`define SNF_WRAP_64 2'h2
`define SNF_WRAP_16 2'h3
`define SNF_HI_Z 4'hf
`define SNF_OE_X2 4'hc
`define SNF_OE_X1 4'hd
`define SNF_SYNC_IDLE 6'h1f
`endif

// ===== include/snf_pkg.sv
// types for the serial nand front end
package snf_pkg;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01, ST_CMD = 7'h02, ST_ADDR = 7'h04, ST_DUMMY = 7'h08,
      ST_DIN = 7'h10, ST_DOUT = 7'h20, ST_DONE = 7'h40
   } snf_state_t;
   typedef logic [1:0] snf_ecc_t;
endpackage

// ===== sim/snf_host.sv
// host serial controller model driving clock, select and io lines
`timescale 1ns/100ps
module snf_host (
   // clock and wire levels
   input wire logic clk_in,
   input wire logic [3:0] io_lvl_in,
   // serial link
   output logic sclk_out,
   output logic cs_n_out,
   output logic [3:0] io_out
);
   logic mode3;
   // deselected: clock at idle level, wp and pause pins high
   initial begin
      mode3 = 1'b0;
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      io_out = 4'hf;
   end
   // wait whole system clocks, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic pin(input int i, input logic v);
      io_out[i] = v;
   endtask
   // one serial clock: data set after fall, rise, sample late in high half
   task automatic cyc(input logic [3:0] d, input logic [3:0] m, output logic [3:0] g);
      io_out = (io_out & ~m) | (d & m);
      tick(4);
      sclk_out = 1'b1;
      tick(3);
      g = io_lvl_in;
      tick(1);
      sclk_out = 1'b0;
   endtask
   task automatic start(input logic m3);
      mode3 = m3;
      sclk_out = m3;
      tick(2);
      cs_n_out = 1'b0;
      tick(4);
      sclk_out = 1'b0;
   endtask
   // pause pin released only after select is high
   task automatic stop();
      tick(4);
      sclk_out = mode3;
      tick(4);
      cs_n_out = 1'b1;
      tick(4);
      io_out = 4'hf;
      tick(6);
   endtask
   task automatic send8(input logic [7:0] v, input int w);
      logic [3:0] g;
      logic [3:0] m;
      m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
      for (int k = 8 - w; k >= 0; k -= w) begin
         cyc(4'((v >> k) & 8'(m)), m, g);
      end
   endtask
   // released lines get a toggling value so stale levels never match
   task automatic recv8(output logic [7:0] b, input int w);
      logic [3:0] g;
      logic [3:0] m;
      m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h2;
      b = 8'h00;
      for (int k = 0; k < 8 / w; k++) begin
         cyc(~io_out, m, g);
         b = (w == 1) ? {b[6:0], g[1]} : (w == 2) ? {b[5:0], g[1:0]} : {b[3:0], g};
      end
   endtask
endmodule // snf_host

// ===== sim/testbench.sv
// self-checking bench for the serial nand front end
`timescale 1ns/100ps
`include "snf_params.svh"
module testbench;
   import snf_pkg::*;
   logic clk_in;
   logic reset_in;
   logic sclk, cs_n, ecc_en, page_wr, page_done, load_req, paused;
   logic [3:0] host_io, io_out, oe_n, io_lvl;
   logic [11:0] page_col;
   logic [7:0] page_data, prot, b;
   logic [15:0] load_row;
   logic [31:0] ecc_code;
   snf_ecc_t page_ecc, ecc_st;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   // wire level: device where enabled, else host
   assign io_lvl = (~oe_n & io_out) | (oe_n & host_io);
   always #25 clk_in = ~clk_in;
   snf_host i_snf_host (.clk_in(clk_in), .io_lvl_in(io_lvl), .sclk_out(sclk), .cs_n_out(cs_n),
      .io_out(host_io));
   snf_front_end i_snf_front_end (.CLK_IN(clk_in), .RESET_IN(reset_in), .SCLK_IN(sclk), .CS_N_IN(cs_n),
      .IO_LINE_IN(io_lvl), .IO_LINE_OUT(io_out), .IO_LINE_OE_N_OUT(oe_n), .ECC_ENABLE_IN(ecc_en),
      .PAGE_WR_IN(page_wr), .PAGE_COL_IN(page_col), .PAGE_DATA_IN(page_data), .PAGE_DONE_IN(page_done),
      .PAGE_ECC_IN(page_ecc), .LOAD_REQ_OUT(load_req), .LOAD_ROW_OUT(load_row), .ECC_CODE_OUT(ecc_code),
      .ECC_STATUS_OUT(ecc_st), .PROTECT_OUT(prot), .PAUSED_OUT(paused));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 40000) begin
         errors = errors + 1;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] pat(input int c);
      return (c >= 2112) ? 8'hff : 8'(c) ^ 8'h5a;
   endfunction
   function automatic int nxt(input int c, input int len);
      return (len == 2112) ? (c + 1) % 2112 : c - c % len + (c % len + 1) % len;
   endfunction
   // set ecc enable, fill every column, one past the end too, then end the load
   task automatic load_page(input logic [1:0] e, input logic en);
      ecc_en = en;
      for (int c = 0; c <= 2112; c++) begin
         @(posedge clk_in);
         #1;
         page_wr = 1'b1;
         page_col = 12'(c);
         page_data = (c == 2112) ? 8'h00 : pat(c);
      end
      @(posedge clk_in);
      #1;
      page_wr = 1'b0;
      page_done = 1'b1;
      page_ecc = e;
      @(posedge clk_in);
      #1;
      page_done = 1'b0;
      @(posedge clk_in);
      #1;
   endtask
   // cache read: opcode, width, wrap code, column, bytes, mode, flip mask
   task automatic rd(input logic [7:0] op, input int w, input logic [1:0] wr, input int c, input int n,
      input logic m3, input logic [7:0] x);
      int len;
      len = (wr == 2'h0) ? 2112 : (wr == 2'h1) ? 2048 : (wr == 2'h2) ? 64 : 16;
      i_snf_host.start(m3);
      i_snf_host.send8(op, 1);
      i_snf_host.send8({wr, 2'h0, 4'(c >> 8)}, 1);
      i_snf_host.send8(8'(c), 1);
      i_snf_host.send8(8'h00, 1);
      for (int k = 0; k < n; k++) begin
         i_snf_host.recv8(b, w);
         chk(b, pat(c) ^ x);
         c = nxt(c, len);
      end
      i_snf_host.stop();
      chk(oe_n, `SNF_HI_Z);
   endtask
   task automatic setf(input logic [7:0] a, input logic [7:0] d);
      i_snf_host.start(1'b0);
      i_snf_host.send8(`SNF_OP_SETF, 1);
      i_snf_host.send8(a, 1);
      i_snf_host.send8(d, 1);
      i_snf_host.stop();
   endtask
   // main sequence
   initial begin
      clk_in = 1'b0;
      reset_in = 1'b1;
      page_wr = 1'b0;
      page_done = 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      reset_in = 1'b0;
      chk(load_req, 1'b1);
      chk(load_row, 16'h0000);
      chk(prot, `SNF_PROT_RST);
      chk(oe_n, `SNF_HI_Z);
      load_page(2'h2, 1'b1);
      chk(load_req, 1'b0);
      chk(ecc_st, 2'h2);
      rd(`SNF_OP_RD, 1, 2'h0, 5, 3, 1'b0, 8'h00);
      rd(`SNF_OP_RD2, 2, 2'h1, 2046, 3, 1'b0, 8'h00);
      rd(`SNF_OP_RD4, 4, 2'h2, 2110, 3, 1'b0, 8'h00);
      rd(`SNF_OP_RD, 1, 2'h0, 2112, 1, 1'b0, 8'h00);
      i_snf_host.start(1'b0);
      i_snf_host.send8(`SNF_OP_PL4, 1);
      i_snf_host.send8(8'h01, 1);
      i_snf_host.send8(8'hff, 1);
      i_snf_host.send8(~pat(511), 4);
      i_snf_host.send8(~pat(512), 4);
      i_snf_host.stop();
      chk(ecc_code, {16'h0000, ~pat(512), ~pat(511)});
      rd(`SNF_OP_RD, 1, 2'h0, 511, 2, 1'b0, 8'hff);
      setf(`SNF_FEAT_PROT, 8'hbf);
      chk(prot, 8'hbe);
      i_snf_host.pin(2, 1'b0);
      setf(`SNF_FEAT_PROT, 8'h00);
      chk(prot, 8'hbe);
      setf(`SNF_FEAT_PROT, 8'h38);
      chk(prot, 8'h38);
      setf(8'hb0, 8'h00);
      chk(prot, 8'h38);
      i_snf_host.start(1'b0);
      i_snf_host.send8(`SNF_OP_GETF, 1);
      i_snf_host.send8(`SNF_FEAT_PROT, 1);
      i_snf_host.recv8(b, 1);
      chk(b, 8'h38);
      i_snf_host.stop();
      // pause mid-read, clocks while paused are ignored
      i_snf_host.start(1'b0);
      i_snf_host.send8(`SNF_OP_RD, 1);
      i_snf_host.send8(8'h00, 1);
      i_snf_host.send8(8'h20, 1);
      i_snf_host.send8(8'h00, 1);
      i_snf_host.recv8(b, 1);
      chk(b, pat(32));
      i_snf_host.pin(3, 1'b0);
      i_snf_host.tick(6);
      chk(paused, 1'b1);
      chk(oe_n, `SNF_HI_Z);
      i_snf_host.send8(8'h00, 1);
      i_snf_host.pin(3, 1'b1);
      i_snf_host.tick(6);
      chk(paused, 1'b0);
      i_snf_host.recv8(b, 1);
      chk(b, pat(33));
      i_snf_host.pin(3, 1'b0);
      i_snf_host.tick(6);
      i_snf_host.cs_n_out = 1'b1;
      i_snf_host.tick(6);
      chk(paused, 1'b0);
      chk(oe_n, `SNF_HI_Z);
      i_snf_host.pin(3, 1'b1);
      i_snf_host.tick(6);
      rd(`SNF_OP_FRD, 1, 2'h0, 2110, 3, 1'b1, 8'h00);
      rd(`SNF_OP_RD, 1, 2'h3, 14, 3, 1'b1, 8'h00);
      load_page(2'h3, 1'b0);
      chk(ecc_st, 2'h0);
      report_and_stop();
   end
endmodule // testbench
